// ---- src/ssp_serial.sv ----
// Overview of operation
// - Mode bits pick sync shift, 10-bit variable, 11-bit fixed, 11-bit variable.
// - Select bit makes control bit 7 a framing error flag; software clears it.
// - Modes 2/3 with multiprocessor set: no receive flag if ninth bit zero.
// - Mode 1 with multiprocessor set: no receive flag without valid stop bit.
// - Mode 0 multiprocessor bit picks shift clock of oscillator/12 or /4.
// - Reception starts only while the receive-enable bit is one.
// - Modes 2/3 send the software transmit ninth bit as ninth data bit.
// - Ninth-bit field holds ninth bit in modes 2/3, stop bit in mode 1.
// - Transmit flag sets after bit 8 in mode 0, stop start otherwise.
// - Receive flag sets after bit 8 in mode 0, mid stop otherwise.
// - Data address reads receive register, writes load the transmit buffer.
// - Transmit activity is high while sending, cleared as transmit flag sets.
// - Receive activity is high while receiving, cleared as receive flag sets.
// - Clock-divide writes are ignored while active with switchback enabled.
// - With switchback, start bit detection in modes 1, 2 and 3 forces clock divide to divide-by-4.
// - Baud doubling bit doubles the bit rate in modes 1, 2 and 3.
// - Address bits compared to slave address only where mask bit is one.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module ssp_serial (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial lines.
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd,
  // System.
  input wire logic timer_ovf,
  output logic [1:0] clk_div,
  output logic irq
);
  import ssp_pkg::*;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SYNC = 3'b100
  } ssp_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS = 4'b0100,
    RX_SYNC = 4'b1000
  } ssp_rx_state_t;

  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic mp_en;
    logic rx_en;
    logic tx9;
    logic rx9;
    logic ti;
    logic ri;
    logic fe;
    logic fe_sel;
    logic baud_dbl;
    logic switchback_enable;
    logic [1:0] cdiv;
    logic [7:0] saddr;
    logic [7:0] smask;
    logic [7:0] rx_data;
    logic [SSP_IRQ_W-1:0] irq_st;
    logic [SSP_IRQ_W-1:0] irq_mask;
    ssp_tx_state_t tx_st;
    logic [10:0] tx_sr;
    logic [3:0] tx_cnt;
    logic [3:0] tx_os;
    ssp_rx_state_t rx_st;
    logic [9:0] rx_sr;
    logic [3:0] rx_cnt;
    logic [3:0] rx_os;
    logic sclk;
    logic tx_act;
    logic rx_act;
    logic sync1;
    logic sync2;
    logic rx_prev;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] rdata;
    logic irq;
    logic txd;
    logic rxd_out;
    logic rxd_oe_n;
  } ssp_state_t;

  ssp_state_t s_q, s_d;
  logic os_tick;
  logic half_tick;
  logic [1:0] mode;
  logic [7:0] wdata;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_idx;
  logic [9:0] rx_new;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic rx_stop;
  logic accept;
  logic addr_ok;
  logic rd_req;
  logic [SSP_IRQ_W-1:0] ev;

  assign mode = {s_q.mode_hi, s_q.mode_lo};
  assign wdata = hwdata[7:0];
  assign rd_idx = haddr[9:2];
  assign rd_req = hsel & htrans[1] & hready & ~hwrite;

  // Tick generator shares one divider between mode 0 and mode 2.
  ssp_tick_gen u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(mode),
    .mp_en(s_q.mp_en),
    .baud_double(s_q.baud_dbl),
    .timer_ovf(timer_ovf),
    .os_tick(os_tick),
    .half_tick(half_tick)
  );

  // Bit 7 shows the error flag or the mode bit, as the select bit decides.
  always_comb begin
    ctrl_rd = {s_q.fe_sel ? s_q.fe : s_q.mode_hi, s_q.mode_lo, s_q.mp_en, s_q.rx_en,
               s_q.tx9, s_q.rx9, s_q.ti, s_q.ri};
  end

  // Read data is latched in the address phase so every transfer is zero wait.
  function automatic logic [7:0] ssp_read(input ssp_state_t st, input logic [7:0] idx,
                                         input logic [7:0] ctl);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      SSP_IDX_CTRL: v = ctl;
      SSP_IDX_DATA: v = st.rx_data;
      SSP_IDX_CLKDIV: v = {st.cdiv, st.switchback_enable, 5'h00};
      SSP_IDX_ACT: v = {4'h0, st.tx_act, st.rx_act, 2'h0};
      SSP_IDX_SADDR: v = st.saddr;
      SSP_IDX_SMASK: v = st.smask;
      SSP_IDX_OPT: v = {st.baud_dbl, st.fe_sel, 6'h00};
      SSP_IDX_IRQ_ST: v = {5'h00, st.irq_st};
      SSP_IDX_IRQ_MASK: v = {5'h00, st.irq_mask};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : ssp_read

  // Received frame layout depends on whether a ninth bit is present.
  always_comb begin
    rx_new = {s_q.sync2, s_q.rx_sr[9:1]};
    if (s_q.mode_hi) begin
      rx_byte = rx_new[7:0];
      rx_ninth = rx_new[8];
    end else begin
      rx_byte = rx_new[8:1];
      rx_ninth = rx_new[9];
    end
    rx_stop = rx_new[9];
    addr_ok = ((rx_byte ^ s_q.saddr) & s_q.smask) == 8'h00;
    if (!s_q.mp_en) begin
      accept = 1'b1;
    end else if (s_q.mode_hi) begin
      accept = rx_ninth & addr_ok;
    end else begin
      accept = rx_stop;
    end
  end

  // Next-state logic: bus writes first, hardware events after so that sets win.
  always_comb begin
    s_d = s_q;
    ev = '0;
    s_d.sync1 = rxd_in;
    s_d.sync2 = s_q.sync1;
    s_d.rx_prev = s_q.sync2;
    s_d.wr_pend = hsel & htrans[1] & hready & hwrite;
    s_d.wr_idx = rd_idx;
    if (rd_req) begin
      s_d.rdata = ssp_read(s_q, rd_idx, ctrl_rd);
    end

    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        SSP_IDX_CTRL: begin
          if (s_q.fe_sel) begin
            s_d.fe = s_q.fe & wdata[SSP_B_MODE_HI];
          end else begin
            s_d.mode_hi = wdata[SSP_B_MODE_HI];
          end
          s_d.mode_lo = wdata[SSP_B_MODE_LO];
          s_d.mp_en = wdata[SSP_B_MP];
          s_d.rx_en = wdata[SSP_B_REN];
          s_d.tx9 = wdata[SSP_B_TX9];
          s_d.rx9 = wdata[SSP_B_RX9];
          s_d.ti = wdata[SSP_B_TI];
          s_d.ri = wdata[SSP_B_RI];
        end
        SSP_IDX_DATA: begin
          // A write while a frame is in flight is dropped; the frame is not cut.
          if ((s_q.tx_st == TX_IDLE) && (s_q.rx_st == RX_IDLE || mode != SSP_MODE_SYNC)) begin
            s_d.tx_act = 1'b1;
            s_d.tx_os = 4'h0;
            if (mode == SSP_MODE_SYNC) begin
              s_d.tx_st = TX_SYNC;
              s_d.tx_sr = {3'h7, wdata};
              s_d.tx_cnt = 4'h0;
              s_d.sclk = 1'b1;
            end else begin
              s_d.tx_st = TX_ASYNC;
              s_d.tx_sr = {1'b1, s_q.mode_hi ? s_q.tx9 : 1'b1, wdata, 1'b0};
              s_d.tx_cnt = s_q.mode_hi ? SSP_BITS_11 : SSP_BITS_10;
            end
          end
        end
        SSP_IDX_CLKDIV: begin
          if (!((s_q.tx_act | s_q.rx_act) & s_q.switchback_enable)) begin
            s_d.cdiv = wdata[SSP_B_CD_HI:SSP_B_CD_LO];
          end
          s_d.switchback_enable = wdata[SSP_B_SWB];
        end
        SSP_IDX_SADDR: s_d.saddr = wdata;
        SSP_IDX_SMASK: s_d.smask = wdata;
        SSP_IDX_OPT: begin
          s_d.baud_dbl = wdata[SSP_B_BAUD_DBL];
          s_d.fe_sel = wdata[SSP_B_FE_SEL];
        end
        SSP_IDX_IRQ_ST: s_d.irq_st = s_q.irq_st & ~wdata[SSP_IRQ_W-1:0];
        SSP_IDX_IRQ_MASK: s_d.irq_mask = wdata[SSP_IRQ_W-1:0];
        default: s_d.irq_st = s_d.irq_st;
      endcase
    end

    // Transmitter.
    case (s_q.tx_st)
      TX_IDLE: s_d.txd = (mode == SSP_MODE_SYNC) ? s_q.sclk : 1'b1;
      TX_ASYNC: begin
        s_d.txd = s_q.tx_sr[0];
        if (os_tick) begin
          s_d.tx_os = s_q.tx_os + 4'h1;
          if (s_q.tx_os == SSP_OS_LAST) begin
            s_d.tx_sr = {1'b1, s_q.tx_sr[10:1]};
            s_d.tx_cnt = s_q.tx_cnt - 4'h1;
            s_d.txd = s_q.tx_sr[1];
            if (s_q.tx_cnt == 4'h2) begin
              s_d.ti = 1'b1;
              s_d.tx_act = 1'b0;
              ev[SSP_IRQ_TX] = 1'b1;
            end
            if (s_q.tx_cnt == 4'h1) begin
              s_d.tx_st = TX_IDLE;
            end
          end
        end
      end
      TX_SYNC: begin
        s_d.rxd_oe_n = 1'b0;
        s_d.rxd_out = s_q.tx_sr[0];
        s_d.txd = s_q.sclk;
        if (half_tick) begin
          s_d.sclk = ~s_q.sclk;
          s_d.txd = ~s_q.sclk;
          if (!s_q.sclk) begin
            s_d.tx_sr = {1'b1, s_q.tx_sr[10:1]};
            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
            if (s_q.tx_cnt == SSP_BITS_SYNC - 4'h1) begin
              s_d.ti = 1'b1;
              s_d.tx_act = 1'b0;
              ev[SSP_IRQ_TX] = 1'b1;
              s_d.tx_st = TX_IDLE;
              s_d.rxd_oe_n = 1'b1;
            end
          end
        end
      end
      default: s_d.tx_st = TX_IDLE;
    endcase

    // Receiver.
    case (s_q.rx_st)
      RX_IDLE: begin
        if (s_q.rx_en && mode != SSP_MODE_SYNC && s_q.rx_prev && !s_q.sync2) begin
          s_d.rx_st = RX_START;
          s_d.rx_os = 4'h0;
          s_d.rx_act = 1'b1;
          if (s_q.switchback_enable) begin
            s_d.cdiv = SSP_CD_DIV4;
          end
        end else if (s_q.rx_en && mode == SSP_MODE_SYNC && !s_q.ri &&
                     s_q.tx_st == TX_IDLE) begin
          s_d.rx_st = RX_SYNC;
          s_d.rx_cnt = 4'h0;
          s_d.rx_act = 1'b1;
          s_d.sclk = 1'b1;
        end
      end
      RX_START: begin
        if (os_tick) begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == SSP_OS_MID) begin
            // A start bit that is high again at mid bit was a glitch.
            s_d.rx_st = s_q.sync2 ? RX_IDLE : RX_BITS;
            s_d.rx_act = ~s_q.sync2;
            s_d.rx_os = 4'h0;
            s_d.rx_cnt = 4'h0;
          end
        end
      end
      RX_BITS: begin
        if (os_tick) begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == SSP_OS_LAST) begin
            s_d.rx_sr = rx_new;
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            if (s_q.rx_cnt + 4'h1 == (s_q.mode_hi ? SSP_RX_SHIFTS_11 : SSP_RX_SHIFTS_10)) begin
              s_d.rx_st = RX_IDLE;
              s_d.rx_act = 1'b0;
              if (!rx_stop) begin
                s_d.fe = 1'b1;
                ev[SSP_IRQ_FE] = 1'b1;
              end
              if (accept) begin
                s_d.rx_data = rx_byte;
                s_d.rx9 = s_q.mode_hi ? rx_ninth : rx_stop;
                s_d.ri = 1'b1;
                ev[SSP_IRQ_RX] = 1'b1;
              end
            end
          end
        end
      end
      RX_SYNC: begin
        s_d.txd = s_q.sclk;
        if (!s_q.rx_en) begin
          s_d.rx_st = RX_IDLE;
          s_d.rx_act = 1'b0;
        end else if (half_tick) begin
          s_d.sclk = ~s_q.sclk;
          s_d.txd = ~s_q.sclk;
          if (!s_q.sclk) begin
            s_d.rx_sr = rx_new;
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            if (s_q.rx_cnt == SSP_BITS_SYNC - 4'h1) begin
              s_d.rx_data = rx_new[9:2];
              s_d.ri = 1'b1;
              s_d.rx_act = 1'b0;
              ev[SSP_IRQ_RX] = 1'b1;
              s_d.rx_st = RX_IDLE;
            end
          end
        end
      end
      default: s_d.rx_st = RX_IDLE;
    endcase

    // Sticky status, set wins over the write-one clear.
    s_d.irq_st = s_d.irq_st | ev;
    s_d.irq = |(s_d.irq_st & s_d.irq_mask);
  end

  // State register; control state starts in mode 0 with divide-by-4.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.tx_st <= TX_IDLE;
      s_q.rx_st <= RX_IDLE;
      s_q.cdiv <= SSP_CD_DIV4;
      s_q.sclk <= 1'b1;
      s_q.sync1 <= 1'b1;
      s_q.sync2 <= 1'b1;
      s_q.rx_prev <= 1'b1;
      s_q.txd <= 1'b1;
      s_q.rxd_out <= 1'b1;
      s_q.rxd_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register; the slave never stalls or errors.
  assign hrdata = {24'h000000, s_q.rdata};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rxd_out = s_q.rxd_out;
  assign rxd_oe_n = s_q.rxd_oe_n;
  assign txd = s_q.txd;
  assign clk_div = s_q.cdiv;
  assign irq = s_q.irq;

endmodule : ssp_serial

`default_nettype wire

// ---- src/ssp_pkg.sv ----
package ssp_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] SSP_IDX_CTRL = 8'hC0;
  localparam logic [7:0] SSP_IDX_DATA = 8'hC1;
  localparam logic [7:0] SSP_IDX_CLKDIV = 8'hC4;
  localparam logic [7:0] SSP_IDX_ACT = 8'hC5;
  localparam logic [7:0] SSP_IDX_SADDR = 8'hAA;
  localparam logic [7:0] SSP_IDX_SMASK = 8'hBA;
  localparam logic [7:0] SSP_IDX_OPT = 8'hE0;
  localparam logic [7:0] SSP_IDX_IRQ_ST = 8'hE1;
  localparam logic [7:0] SSP_IDX_IRQ_MASK = 8'hE2;

  // Control register bit positions.
  localparam int SSP_B_MODE_HI = 7;
  localparam int SSP_B_MODE_LO = 6;
  localparam int SSP_B_MP = 5;
  localparam int SSP_B_REN = 4;
  localparam int SSP_B_TX9 = 3;
  localparam int SSP_B_RX9 = 2;
  localparam int SSP_B_TI = 1;
  localparam int SSP_B_RI = 0;

  // Clock divide register, activity register and option register fields.
  localparam int SSP_B_CD_HI = 7;
  localparam int SSP_B_CD_LO = 6;
  localparam int SSP_B_SWB = 5;
  localparam int SSP_B_TX_ACT = 3;
  localparam int SSP_B_RX_ACT = 2;
  localparam int SSP_B_BAUD_DBL = 7;
  localparam int SSP_B_FE_SEL = 6;

  // Interrupt status bits.
  localparam int SSP_IRQ_W = 3;
  localparam int SSP_IRQ_RX = 0;
  localparam int SSP_IRQ_TX = 1;
  localparam int SSP_IRQ_FE = 2;

  // Mode codes and clock divide values.
  localparam logic [1:0] SSP_MODE_SYNC = 2'h0;
  localparam logic [1:0] SSP_MODE_1 = 2'h1;
  localparam logic [1:0] SSP_MODE_FIXED = 2'h2;
  localparam logic [1:0] SSP_CD_DIV4 = 2'h1;

  // Timing: oversampling ticks per bit and clock divisions per tick.
  localparam logic [3:0] SSP_OS_LAST = 4'hF;
  localparam logic [3:0] SSP_OS_MID = 4'h7;
  localparam logic [3:0] SSP_DIV_M0_SLOW = 4'h6;
  localparam logic [3:0] SSP_DIV_M0_FAST = 4'h2;
  localparam logic [3:0] SSP_DIV_M2_SLOW = 4'h4;
  localparam logic [3:0] SSP_DIV_M2_FAST = 4'h2;
  localparam logic [3:0] SSP_BITS_SYNC = 4'h8;
  localparam logic [3:0] SSP_BITS_10 = 4'hA;
  localparam logic [3:0] SSP_BITS_11 = 4'hB;

  // Receiver shifts needed after the start bit for 10 and 11 bit frames.
  localparam logic [3:0] SSP_RX_SHIFTS_10 = 4'h9;
  localparam logic [3:0] SSP_RX_SHIFTS_11 = 4'hA;

endpackage : ssp_pkg

// ---- src/ssp_tick_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

module ssp_tick_gen (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration.
  input wire logic [1:0] mode,
  input wire logic mp_en,
  input wire logic baud_double,
  input wire logic timer_ovf,
  // Ticks.
  output logic os_tick,
  output logic half_tick
);
  import ssp_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic ovf_ph;
    logic os_tick;
    logic half_tick;
  } ssp_tick_state_t;

  ssp_tick_state_t s_q, s_d;
  logic [3:0] period;

  // One divider serves mode 0 and mode 2, since only one mode runs at a time.
  always_comb begin
    s_d = s_q;
    s_d.os_tick = 1'b0;
    s_d.half_tick = 1'b0;
    if (mode == SSP_MODE_SYNC) begin
      period = mp_en ? SSP_DIV_M0_FAST : SSP_DIV_M0_SLOW;
    end else begin
      period = baud_double ? SSP_DIV_M2_FAST : SSP_DIV_M2_SLOW;
    end
    if (s_q.cnt >= period - 4'h1) begin
      s_d.cnt = 4'h0;
      s_d.half_tick = (mode == SSP_MODE_SYNC);
      s_d.os_tick = (mode == SSP_MODE_FIXED);
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
    // Variable rate modes take every overflow when doubled, else every other one.
    if ((mode == SSP_MODE_1) || (mode == 2'h3)) begin
      if (timer_ovf) begin
        s_d.ovf_ph = ~s_q.ovf_ph;
        s_d.os_tick = baud_double | s_q.ovf_ph;
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign os_tick = s_q.os_tick;
  assign half_tick = s_q.half_tick;

endmodule : ssp_tick_gen

`default_nettype wire

// ---- sim/ssp_serial_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssp_serial_chk import ssp_pkg::*; (
  // Bus.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins.
  input wire logic txd,
  input wire logic [1:0] clk_div,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] wr_age;
  logic go;
  // A transfer is taken whenever the slave is selected, ready and asked.
  assign go = hsel && hready && htrans[1];
  sequence rd_unmapped;
    go && !hwrite && haddr[9:2] < SSP_IDX_SADDR;
  endsequence
  // Age of the last write; it saturates so that any old write looks the same.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_age <= 3'h7;
    end else if (go && hwrite) begin
      wr_age <= 3'h0;
    end else if (wr_age != 3'h7) begin
      wr_age <= wr_age + 3'h1;
    end
  end
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  unmapped_zero_a: assert property (rd_unmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(go && !hwrite))
    else $error("read data moved without a read");
  reset_idle_a: assert property ($rose(hresetn) |-> txd && !irq && clk_div == SSP_CD_DIV4)
    else $error("outputs not idle after reset");
  txd_low_min_a: assert property ($fell(txd) |=> !txd)
    else $error("txd low for one cycle only");
  txd_high_min_a: assert property ($rose(txd) |=> txd)
    else $error("txd high for one cycle only");
  irq_fall_a: assert property ($fell(irq) |-> wr_age <= 3'h4)
    else $error("irq dropped without a write");
  clkdiv_cause_a: assert property ($changed(clk_div) && clk_div != SSP_CD_DIV4 |-> wr_age <= 3'h4)
    else $error("clock divide changed without a write");
endmodule : ssp_serial_chk
`default_nettype wire

// ---- sim/ssp_remote_node.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssp_remote_node (
  // Clock.
  input wire logic hclk,
  // Serial lines.
  input wire logic txd,
  output logic rxd
);
  int bit_clks = 64;
  int frames = 0;
  bit listen = 1'b0;
  logic [9:0] got;
  initial rxd = 1'b1;
  // Waits to the centre of a start bit, then samples nine data bits LSB first and the stop bit.
  initial begin
    forever begin
      @(posedge hclk);
      if (listen && txd === 1'b0) begin
        repeat (bit_clks / 2) @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
          repeat (bit_clks) @(posedge hclk);
          got[i] = txd;
        end
        frames++;
      end
    end
  end
  // Sends one frame; a low stop_ok makes a framing fault on purpose.
  task automatic send(input logic [7:0] d, input logic nine, input logic nine_en,
                      input logic stop_ok);
    logic [10:0] fr;
    fr = nine_en ? {stop_ok, nine, d, 1'b0} : {1'b1, stop_ok, d, 1'b0};
    for (int i = 0; i < (nine_en ? 11 : 10); i++) begin
      rxd <= fr[i];
      repeat (bit_clks) @(posedge hclk);
    end
    rxd <= 1'b1;
  endtask : send
endmodule : ssp_remote_node
`default_nettype wire

// ---- sim/second_serial_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module second_serial_port_tb_top;
  import ssp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic timer_ovf = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rxd_out, rxd_oe_n, txd, irq, node_rxd, rxd_line;
  logic [1:0] clk_div;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // Mode 0 data seen on the shared rxd wire, one bit per shift clock low half.
  logic [7:0] m0_bits = 8'h00;
  logic txd_prev = 1'b1;
  // The shared rxd wire: the device drives it only in synchronous mode.
  assign rxd_line = rxd_oe_n ? node_rxd : rxd_out;
  ssp_serial uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd_line),
    .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd), .timer_ovf(timer_ovf),
    .clk_div(clk_div), .irq(irq));
  ssp_remote_node node (.hclk(hclk), .txd(txd), .rxd(node_rxd));
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  // Overflow every other clock gives 64 clocks a bit in the timer modes.
  always @(posedge hclk) begin
    timer_ovf <= ~timer_ovf;
    // The data bit stands through the whole low half, so one clock after the fall is safe.
    if (txd_prev && !txd && !rxd_oe_n) begin
      m0_bits = {rxd_out, m0_bits[7:1]};
    end
    txd_prev = txd;
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One single transfer, then an idle cycle so a later read sees the write.
  task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    bus(1'b1, idx, v, d);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk($sformatf("reg %h", idx), d, {24'h0, e});
  endtask : rdc
  // Waits for the node to finish a frame, then for the stop bit to end.
  task automatic wait_tx(input int n, input logic [9:0] e);
    for (int k = 0; k < 2000 && node.frames < n; k++) @(posedge hclk);
    chk("tx frame", {22'h0, node.got}, {22'h0, e});
    repeat (node.bit_clks) @(posedge hclk);
  endtask : wait_tx
  // Measures one low half of the synchronous shift clock.
  task automatic m0_half(input logic mp, input int e);
    int c;
    wr(SSP_IDX_CTRL, {2'h0, mp, 5'h0});
    wr(SSP_IDX_DATA, 8'h96);
    @(posedge txd);
    @(negedge txd);
    c = cyc;
    @(posedge txd);
    chk("shift half", 32'(cyc - c), 32'(e));
    repeat (120) @(posedge hclk);
    rdc(SSP_IDX_CTRL, {2'h0, mp, 5'h2});
    chk("shift data", {24'h0, m0_bits}, 32'h96);
  endtask : m0_half
  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(SSP_IDX_CTRL, 8'h00);
    rdc(SSP_IDX_CLKDIV, 8'h40);
    rdc(8'h55, 8'h00);
    wr(SSP_IDX_IRQ_MASK, 8'h07);
    // Transmit in modes 2, 3 and doubled mode 2.
    node.listen = 1'b1;
    wr(SSP_IDX_CTRL, 8'h88);
    wr(SSP_IDX_DATA, 8'hA5);
    rdc(SSP_IDX_ACT, 8'h08);
    wait_tx(1, 10'h3A5);
    rdc(SSP_IDX_CTRL, 8'h8A);
    rdc(SSP_IDX_ACT, 8'h00);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(SSP_IDX_IRQ_ST, 8'h02);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(SSP_IDX_CTRL, 8'hC0);
    wr(SSP_IDX_DATA, 8'h5A);
    wait_tx(2, 10'h25A);
    wr(SSP_IDX_OPT, 8'h80);
    node.bit_clks = 32;
    wr(SSP_IDX_CTRL, 8'h88);
    wr(SSP_IDX_DATA, 8'h3C);
    wait_tx(3, 10'h33C);
    wr(SSP_IDX_OPT, 8'h00);
    node.bit_clks = 64;
    node.listen = 1'b0;
    // Receive in mode 2, with and without enable and address filtering.
    wr(SSP_IDX_CTRL, 8'h80);
    node.send(8'h5A, 1'b1, 1'b1, 1'b1);
    rdc(SSP_IDX_CTRL, 8'h80);
    wr(SSP_IDX_CTRL, 8'h90);
    node.send(8'h5A, 1'b1, 1'b1, 1'b1);
    rdc(SSP_IDX_CTRL, 8'h95);
    wr(SSP_IDX_DATA, 8'h11);
    rdc(SSP_IDX_DATA, 8'h5A);
    wr(SSP_IDX_CTRL, 8'hB0);
    wr(SSP_IDX_IRQ_ST, 8'h07);
    node.send(8'h33, 1'b0, 1'b1, 1'b1);
    rdc(SSP_IDX_IRQ_ST, 8'h02);
    wr(SSP_IDX_SMASK, 8'hFF);
    wr(SSP_IDX_SADDR, 8'h44);
    node.send(8'h45, 1'b1, 1'b1, 1'b1);
    rdc(SSP_IDX_IRQ_ST, 8'h02);
    node.send(8'h44, 1'b1, 1'b1, 1'b1);
    // The transmit flag of the earlier 0x11 frame is still set here.
    rdc(SSP_IDX_CTRL, 8'hB7);
    rdc(SSP_IDX_DATA, 8'h44);
    // Mode 1: framing fault, then a good frame with switchback.
    // Mode bits go in before bit 7 turns into the error flag, or mode_hi would stay set from mode 2 and give mode 3.
    wr(SSP_IDX_SMASK, 8'h00);
    wr(SSP_IDX_CTRL, 8'h70);
    wr(SSP_IDX_OPT, 8'h40);
    wr(SSP_IDX_IRQ_ST, 8'h07);
    node.send(8'h81, 1'b0, 1'b0, 1'b0);
    rdc(SSP_IDX_CTRL, 8'hF0);
    rdc(SSP_IDX_IRQ_ST, 8'h04);
    wr(SSP_IDX_CTRL, 8'h50);
    rdc(SSP_IDX_CTRL, 8'h50);
    wr(SSP_IDX_IRQ_ST, 8'h07);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(SSP_IDX_CLKDIV, 8'hE0);
    chk("clk_div", {30'h0, clk_div}, 32'h3);
    fork
      node.send(8'hC3, 1'b0, 1'b0, 1'b1);
      begin
        repeat (40) @(posedge hclk);
        chk("clk_div", {30'h0, clk_div}, 32'h1);
        rdc(SSP_IDX_ACT, 8'h04);
        wr(SSP_IDX_CLKDIV, 8'hE0);
        chk("clk_div", {30'h0, clk_div}, 32'h1);
      end
    join
    rdc(SSP_IDX_CTRL, 8'h55);
    rdc(SSP_IDX_DATA, 8'hC3);
    rdc(SSP_IDX_ACT, 8'h00);
    m0_half(1'b0, 6);
    m0_half(1'b1, 2);
    // Mode 0 reception clocks in eight bits of the idle-high line.
    wr(SSP_IDX_CTRL, 8'h30);
    repeat (60) @(posedge hclk);
    rdc(SSP_IDX_CTRL, 8'h31);
    rdc(SSP_IDX_DATA, 8'hFF);
    wrap_up();
  end
endmodule : second_serial_port_tb_top
bind ssp_serial ssp_serial_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .clk_div(clk_div), .irq(irq));
`default_nettype wire
